// ===== rtl/e1_nbit_map.svh
`ifndef E1_NBIT_MAP_SVH
`define E1_NBIT_MAP_SVH
// ****************************************************************
// Timing
// ****************************************************************
`define CLK_HZ           10_000_000
`define CLK_PER_MS       (`CLK_HZ / 1000)
`define RAI_TIME_MS      10
`define SEC_TIME_S       1
`define CNT_W            24
`define FEBE_MIN_PER_SEC 10'd990
`define FEBE_SECONDS     5
`define FEBE_CNT_MAX     10'h3FF
// ****************************************************************
// Register indexes (byte address = 4 * index)
// ****************************************************************
`define MAX_LINKS        4
`define LINK_IDX_LSB     8
`define OFS_SPARE4_CW    8'h56
`define OFS_SPARE5_CW    8'h57
`define OFS_SPARE6_CW    8'h58
`define OFS_SPARE7_CW    8'h59
`define OFS_SPARE8_CW    8'h5A
`define OFS_PAT_FLAGS    8'h5B
`define OFS_CW_IRQ_EN    8'h5C
`define OFS_CW_IRQ_FLAGS 8'h5D
`define OFS_OH_STATE     8'h5F
`define OFS_OH_IRQ_EN    8'h60
`define OFS_OH_IRQ_FLAGS 8'h61
`define RST_REG          8'h00
// ****************************************************************
// Field positions
// ****************************************************************
`define CWEN_ALIGN       7
`define CWEN_DEBOUNCE    6
`define CW_SPECIAL       5
`define CW_SPARE6        2
`define OH_NT_CRC        5
`define OH_RAI           2
`define OH_CFEBE         1
`define OH_LINK          0
// ****************************************************************
// Codes
// ****************************************************************
`define PAT_F            12'hFFF
`define PAT_E            12'hEEE
`define PAT_C            12'hCCC
`define PAT_A            12'hAAA
`define PAT_8            12'h888
`define SA6_WIN_BITS     4'hC
`define SA6_WIN_CWS      2'h3
`define SA7_WIN          2'h3
`define NT_CRC_CODE_A    4'h2
`define NT_CRC_CODE_B    4'h3
`endif

// ===== rtl/e1_nbit_pkg.sv
`default_nettype none
`include "e1_nbit_map.svh"
package e1_nbit_pkg;
  typedef struct packed {
    logic [4:0][3:0]   cw;
    logic [4:0][3:0]   rx_prev;
    logic [11:0]       sa6_bits;
    logic [3:0]        bit_fill;
    logic [11:0]       sa6_cws;
    logic [1:0]        cw_fill;
    logic [4:0]        pat_flags;
    logic [5:0]        cw_flags;
    logic [7:0]        cw_en;
    logic [5:0]        oh_en;
    logic [5:0]        oh_flags;
    logic              a_last;
    logic              e_zero;
    logic [`CNT_W-1:0] rai_cnt;
    logic              rai_state;
    logic [9:0]        ezero_cnt;
    logic [4:0]        sec_hist;
    logic [2:0]        sa7_hist;
    logic [1:0]        sa7_fill;
    logic              link_state;
  } link_state_t;

  typedef link_state_t [`MAX_LINKS-1:0] link_arr_t;

  typedef struct packed {
    link_arr_t         lk;
    logic [`CNT_W-1:0] sec_cnt;
    logic [31:0]       prdata;
    logic              err;
    logic              irq;
  } mon_state_t;
endpackage : e1_nbit_pkg
`default_nettype wire

// ===== rtl/e1_nbit_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "e1_nbit_map.svh"
module e1_nbit_monitor import e1_nbit_pkg::*; #(
  parameter int LINKS      = `MAX_LINKS,
  parameter int RAI_CYCLES = `RAI_TIME_MS * `CLK_PER_MS,
  parameter int SEC_CYCLES = `SEC_TIME_S * `CLK_HZ
) (
  input  wire logic                    CLK_I,
  input  wire logic                    RST_N_I,
  input  wire logic                    PSEL_I,
  input  wire logic                    PENABLE_I,
  input  wire logic                    PWRITE_I,
  input  wire logic [11:0]             PADDR_I,
  input  wire logic [31:0]             PWDATA_I,
  input  wire logic [3:0]              PSTRB_I,
  output logic      [31:0]             PRDATA_O,
  output logic                         PREADY_O,
  output logic                         PSLVERR_O,
  input  wire logic [LINKS-1:0]        CRC_MF_SYNC_I,
  input  wire logic [LINKS-1:0]        BASIC_SYNC_I,
  input  wire logic [LINKS-1:0]        SMF_BOUND_I,
  input  wire logic [LINKS-1:0][19:0]  SA_CW_I,
  input  wire logic [LINKS-1:0]        NFAS_STB_I,
  input  wire logic [LINKS-1:0]        A_BIT_I,
  input  wire logic [LINKS-1:0]        SA6_BIT_I,
  input  wire logic [LINKS-1:0]        SA7_BIT_I,
  input  wire logic [LINKS-1:0]        E_STB_I,
  input  wire logic [LINKS-1:0]        E_BIT_I,
  output logic                         INT_O
);
  // ****************************************************************
  // Elaboration checks and constants
  // ****************************************************************
  if (LINKS < 1 || LINKS > `MAX_LINKS) begin : g_bad_links
    $error("LINKS out of range");
  end
  if (RAI_CYCLES < 1 || RAI_CYCLES >= (1 << `CNT_W)) begin : g_bad_rai
    $error("RAI_CYCLES out of range");
  end
  if (SEC_CYCLES < 2 || SEC_CYCLES >= (1 << `CNT_W)) begin : g_bad_sec
    $error("SEC_CYCLES out of range");
  end

  localparam logic [`CNT_W-1:0] RAI_LAST = `CNT_W'(RAI_CYCLES - 1);
  localparam logic [`CNT_W-1:0] SEC_LAST = `CNT_W'(SEC_CYCLES - 1);

  mon_state_t s_r;
  mon_state_t s_nxt;

  logic       setup;
  logic       wr_go;
  logic [1:0] acc_link;
  logic [7:0] acc_ofs;
  logic       sec_tick;

  assign setup    = PSEL_I & ~PENABLE_I;
  assign wr_go    = PSEL_I & PENABLE_I & PWRITE_I & PSTRB_I[0];
  assign acc_link = PADDR_I[11:10];
  assign acc_ofs  = PADDR_I[9:2];
  assign sec_tick = (s_r.sec_cnt == SEC_LAST);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [4:0] pat_match(input logic [11:0] w);
    pat_match = {w == `PAT_F, w == `PAT_E, w == `PAT_C,
                 w == `PAT_A, w == `PAT_8};
  endfunction : pat_match

  function automatic logic two_zeros(input logic [2:0] h);
    two_zeros = (~h[0] & ~h[1]) | (~h[0] & ~h[2]) | (~h[1] & ~h[2]);
  endfunction : two_zeros

  function automatic logic [8:0] reg_read(input link_state_t l,
                                          input logic [7:0]  ofs);
    reg_read = 9'h000;
    case (ofs)
      `OFS_SPARE4_CW:    reg_read = {5'h10, l.cw[4]};
      `OFS_SPARE5_CW:    reg_read = {5'h10, l.cw[3]};
      `OFS_SPARE6_CW:    reg_read = {5'h10, l.cw[2]};
      `OFS_SPARE7_CW:    reg_read = {5'h10, l.cw[1]};
      `OFS_SPARE8_CW:    reg_read = {5'h10, l.cw[0]};
      `OFS_PAT_FLAGS:    reg_read = {4'h8, l.pat_flags};
      `OFS_CW_IRQ_EN:    reg_read = {1'b1, l.cw_en};
      `OFS_CW_IRQ_FLAGS: reg_read = {3'h4, l.cw_flags};
      `OFS_OH_STATE:     reg_read = {6'h20, l.rai_state, &l.sec_hist,
                                     l.link_state};
      `OFS_OH_IRQ_EN:    reg_read = {3'h4, l.oh_en};
      `OFS_OH_IRQ_FLAGS: reg_read = {3'h4, l.oh_flags};
      default:           reg_read = 9'h000;
    endcase
  endfunction : reg_read

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    link_state_t     l;
    logic [4:0][3:0] rx;
    logic [4:0][3:0] newv;
    logic            wsel;
    logic [7:0]      wd;
    logic            sync;
    logic            bnd;
    logic            deb;
    logic            align;
    logic            zinc;
    logic [5:0]      cw_set;
    logic [5:0]      cw_clr;
    logic [4:0]      pat_set;
    logic [4:0]      pat_clr;
    logic [5:0]      oh_set;
    logic [5:0]      oh_clr;
    logic [8:0]      rd;
    logic            irq;
    l       = '0;
    rx      = '0;
    newv    = '0;
    wsel    = 1'b0;
    wd      = PWDATA_I[7:0];
    sync    = 1'b0;
    bnd     = 1'b0;
    deb     = 1'b0;
    align   = 1'b0;
    zinc    = 1'b0;
    cw_set  = '0;
    cw_clr  = '0;
    pat_set = '0;
    pat_clr = '0;
    oh_set  = '0;
    oh_clr  = '0;
    rd      = 9'h000;
    irq     = 1'b0;
    s_nxt   = s_r;

    s_nxt.sec_cnt = sec_tick ? '0 : s_r.sec_cnt + `CNT_W'(1);

    if (setup) begin
      if (int'(acc_link) < LINKS) begin
        rd = reg_read(s_r.lk[acc_link], acc_ofs);
      end
      s_nxt.err    = ~rd[8];
      s_nxt.prdata = {24'h00_0000, rd[7:0]};
    end

    for (int i = 0; i < LINKS; i++) begin
      l       = s_r.lk[i];
      rx      = SA_CW_I[i];
      sync    = CRC_MF_SYNC_I[i];
      bnd     = SMF_BOUND_I[i] & sync;
      deb     = l.cw_en[`CWEN_DEBOUNCE];
      align   = l.cw_en[`CWEN_ALIGN];
      wsel    = wr_go & (acc_link == 2'(i));
      cw_set  = '0;
      cw_clr  = '0;
      pat_set = '0;
      pat_clr = '0;
      oh_set  = '0;
      oh_clr  = '0;

      // Codeword extraction
      if (bnd) begin
        for (int k = 0; k < 5; k++) begin
          if (!deb) begin
            newv[k] = rx[k];
          end else if (rx[k] == l.rx_prev[k]) begin
            newv[k] = rx[k];
          end else begin
            newv[k] = l.cw[k];
          end
          cw_set[k]    = (newv[k] != l.cw[k]);
          l.cw[k]      = newv[k];
          l.rx_prev[k] = rx[k];
        end
      end

      // Sa6 special patterns
      if (!sync) begin
        l.bit_fill = '0;
        l.cw_fill  = '0;
      end
      if (sync && NFAS_STB_I[i]) begin
        l.sa6_bits = {l.sa6_bits[10:0], SA6_BIT_I[i]};
        if (l.bit_fill != `SA6_WIN_BITS) begin
          l.bit_fill = l.bit_fill + 4'h1;
        end
        if (!align && l.bit_fill == `SA6_WIN_BITS) begin
          pat_set = pat_set | pat_match(l.sa6_bits);
        end
      end
      if (bnd) begin
        l.sa6_cws = {l.sa6_cws[7:0], rx[`CW_SPARE6]};
        if (l.cw_fill != `SA6_WIN_CWS) begin
          l.cw_fill = l.cw_fill + 2'h1;
        end
        if (align && l.cw_fill == `SA6_WIN_CWS) begin
          pat_set = pat_set | pat_match(l.sa6_cws);
        end
      end
      cw_set[`CW_SPECIAL] = |pat_set;

      // NT CRC error
      if (bnd && (rx[`CW_SPARE6] == `NT_CRC_CODE_A ||
                  rx[`CW_SPARE6] == `NT_CRC_CODE_B)) begin
        oh_set[`OH_NT_CRC] = 1'b1;
      end

      // V5.2 link ID
      if (!BASIC_SYNC_I[i]) begin
        l.sa7_fill = '0;
      end else if (NFAS_STB_I[i]) begin
        l.sa7_hist = {l.sa7_hist[1:0], SA7_BIT_I[i]};
        if (l.sa7_fill != `SA7_WIN) begin
          l.sa7_fill = l.sa7_fill + 2'h1;
        end
      end
      l.link_state = BASIC_SYNC_I[i] & (l.sa7_fill == `SA7_WIN) &
                     two_zeros(l.sa7_hist);

      // Continuous RAI and FEBE
      if (NFAS_STB_I[i]) begin
        l.a_last = A_BIT_I[i];
      end
      if (E_STB_I[i]) begin
        l.e_zero = ~E_BIT_I[i];
      end
      if (!sync || !(l.a_last && l.e_zero)) begin
        l.rai_cnt   = '0;
        l.rai_state = 1'b0;
      end else if (l.rai_cnt == RAI_LAST) begin
        l.rai_state = 1'b1;
      end else begin
        l.rai_cnt = l.rai_cnt + `CNT_W'(1);
      end

      // Continuous FEBE, per-second zero counts
      zinc = E_STB_I[i] & ~E_BIT_I[i];
      if (!sync) begin
        l.ezero_cnt = '0;
        l.sec_hist  = '0;
      end else if (sec_tick) begin
        l.sec_hist  = {l.sec_hist[3:0],
                       l.ezero_cnt >= `FEBE_MIN_PER_SEC};
        l.ezero_cnt = {9'h000, zinc};
      end else if (zinc && l.ezero_cnt != `FEBE_CNT_MAX) begin
        l.ezero_cnt = l.ezero_cnt + 10'h001;
      end

      // Status transitions
      oh_set[`OH_RAI]   = l.rai_state != s_r.lk[i].rai_state;
      oh_set[`OH_CFEBE] = (&l.sec_hist) != (&s_r.lk[i].sec_hist);
      oh_set[`OH_LINK]  = l.link_state != s_r.lk[i].link_state;

      // Register writes
      if (wsel) begin
        case (acc_ofs)
          `OFS_PAT_FLAGS:    pat_clr = wd[4:0];
          `OFS_CW_IRQ_EN:    l.cw_en = wd;
          `OFS_CW_IRQ_FLAGS: cw_clr  = wd[5:0];
          `OFS_OH_IRQ_EN:    l.oh_en = wd[5:0];
          `OFS_OH_IRQ_FLAGS: oh_clr  = wd[5:0];
          default:           cw_clr  = '0;
        endcase
      end
      l.pat_flags = (l.pat_flags & ~pat_clr) | pat_set;
      l.cw_flags  = (l.cw_flags & ~cw_clr) | cw_set;
      l.oh_flags  = (l.oh_flags & ~oh_clr) | oh_set;

      // Interrupt gating
      irq = irq | (|(l.cw_flags[4:0] & l.cw_en[4:0]));
      irq = irq | (l.cw_flags[`CW_SPECIAL] &
                   l.cw_en[`CW_SPECIAL]);
      irq = irq | (l.oh_flags[`OH_NT_CRC] &
                   l.oh_en[`OH_NT_CRC]);
      irq = irq | (|(l.oh_flags & l.oh_en));
      s_nxt.lk[i] = l;
    end
    s_nxt.irq = irq;
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign PRDATA_O  = s_r.prdata;
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & s_r.err;
  assign INT_O     = s_r.irq;

  // ****************************************************************
  // Checks on link 0, and on INT_O over all links
  // ****************************************************************
  link_state_t l0;
  logic        bnd0;
  logic        irq_now;
  logic        wclr0;

  assign l0      = s_r.lk[0];
  assign bnd0    = SMF_BOUND_I[0] & CRC_MF_SYNC_I[0];
  assign wclr0   = wr_go & (acc_link == 2'h0) &
                   (acc_ofs == `OFS_CW_IRQ_FLAGS) & PWDATA_I[4];
  always_comb begin
    irq_now = 1'b0;
    for (int i = 0; i < LINKS; i++) begin
      irq_now = irq_now | (|(s_r.lk[i].cw_flags & s_r.lk[i].cw_en[5:0])) |
                (|(s_r.lk[i].oh_flags & s_r.lk[i].oh_en));
    end
  end

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  sequence s_deb_bound;
    bnd0 && l0.cw_en[`CWEN_DEBOUNCE];
  endsequence

  sequence s_same_twice;
    s_deb_bound ##0 (SA_CW_I[0][11:8] == l0.rx_prev[`CW_SPARE6]);
  endsequence

  chk_hold_nosync: assert property (
    !CRC_MF_SYNC_I[0] |=> $stable(l0.cw))
    else $error("codeword changed out of sync");

  chk_deb_update: assert property (
    s_same_twice |=> l0.cw[`CW_SPARE6] == $past(SA_CW_I[0][11:8]))
    else $error("debounced codeword not taken");

  chk_deb_hold: assert property (
    s_deb_bound ##0 (SA_CW_I[0][11:8] != l0.rx_prev[`CW_SPARE6])
    |=> $stable(l0.cw[`CW_SPARE6]))
    else $error("codeword taken before repeat");

  chk_nodeb_refresh: assert property (
    bnd0 && !l0.cw_en[`CWEN_DEBOUNCE] |=> l0.cw == $past(SA_CW_I[0]))
    else $error("codeword not refreshed");

  chk_change_flag: assert property (
    $changed(l0.cw[4]) |-> l0.cw_flags[4])
    else $error("change flag missing");

  chk_special_sum: assert property (
    |(l0.pat_flags & ~$past(l0.pat_flags)) |-> l0.cw_flags[`CW_SPECIAL])
    else $error("summary flag missing");

  chk_nt_crc: assert property (
    bnd0 && (SA_CW_I[0][11:8] == `NT_CRC_CODE_A ||
             SA_CW_I[0][11:8] == `NT_CRC_CODE_B)
    |=> l0.oh_flags[`OH_NT_CRC])
    else $error("nt crc event missing");

  chk_link_drop: assert property (
    !BASIC_SYNC_I[0] |=> !l0.link_state ##1 !l0.link_state[*2])
    else $error("link id without basic sync");

  chk_rai_timer: assert property (
    $rose(l0.rai_state) |-> $past(l0.rai_cnt) == RAI_LAST &&
                            $past(CRC_MF_SYNC_I[0]))
    else $error("rai state early");

  chk_rai_toggle: assert property (
    $changed(l0.rai_state) |-> l0.oh_flags[`OH_RAI])
    else $error("rai transition not flagged");

  chk_febe_tick: assert property (
    $rose(&l0.sec_hist) |-> $past(sec_tick))
    else $error("febe state off second tick");

  chk_w1c_clear: assert property (
    wclr0 |=> !l0.cw_flags[4] || $changed(l0.cw[4]))
    else $error("flag not cleared");

  chk_irq_gate: assert property (
    ##1 INT_O == $past(irq_now, 1) || $changed(irq_now) || INT_O == irq_now)
    else $error("interrupt mismatch");

  chk_irq_level: assert property (
    INT_O == irq_now)
    else $error("interrupt not from enabled flags");

endmodule : e1_nbit_monitor
`default_nettype wire

// ===== sim/e1_line_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Receive aligner stand-in, drives link 0 only
// ****************************************************************
module e1_line_model (
  input  wire logic             clk_i,
  output logic      [3:0]       crc_sync_o,
  output logic      [3:0]       bas_sync_o,
  output logic      [3:0]       smf_o,
  output logic      [3:0][19:0] cw_o,
  output logic      [3:0]       nfas_o,
  output logic      [3:0]       a_o,
  output logic      [3:0]       sa6_o,
  output logic      [3:0]       sa7_o,
  output logic      [3:0]       estb_o,
  output logic      [3:0]       e_o
);
  initial begin
    {crc_sync_o, bas_sync_o, smf_o, cw_o} = '0;
    {nfas_o, a_o, sa6_o, sa7_o, estb_o, e_o} = '0;
  end

  task automatic sync(input logic crc, input logic bas);
    @(posedge clk_i);
    crc_sync_o <= {3'b000, crc};
    bas_sync_o <= {3'b000, bas};
  endtask : sync

  // Data lines turn to the inverse once the strobe is gone
  task automatic smf(input logic [19:0] cw);
    @(posedge clk_i);
    smf_o   <= 4'h1;
    cw_o[0] <= cw;
    @(posedge clk_i);
    smf_o   <= 4'h0;
    cw_o[0] <= ~cw;
  endtask : smf

  task automatic nfas(input logic a, input logic s6, input logic s7);
    @(posedge clk_i);
    nfas_o <= 4'h1;
    a_o    <= {3'b000, a};
    sa6_o  <= {3'b000, s6};
    sa7_o  <= {3'b000, s7};
    @(posedge clk_i);
    nfas_o <= 4'h0;
    a_o    <= {3'b000, ~a};
    sa6_o  <= {3'b000, ~s6};
    sa7_o  <= {3'b000, ~s7};
  endtask : nfas

  // E strobe held high for n cycles
  task automatic erun(input int n, input logic e);
    @(posedge clk_i);
    estb_o <= 4'h1;
    e_o    <= {3'b000, e};
    repeat (n) @(posedge clk_i);
    estb_o <= 4'h0;
    e_o    <= {3'b000, ~e};
  endtask : erun
endmodule : e1_line_model
`default_nettype wire

// ===== sim/test_e1_national_bit_overhead_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "e1_nbit_map.svh"
module test_e1_national_bit_overhead_monitor;
  localparam int RAI_C = 20;
  localparam int SEC_C = 1000;
  logic             clk = 1'b0;
  logic             rst_n;
  logic             psel;
  logic             penable;
  logic             pwrite;
  logic [11:0]      paddr;
  logic [31:0]      pwdata;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic             irq;
  logic [3:0]       crc;
  logic [3:0]       bas;
  logic [3:0]       smf;
  logic [3:0][19:0] cw;
  logic [3:0]       nfas;
  logic [3:0]       a;
  logic [3:0]       s6;
  logic [3:0]       s7;
  logic [3:0]       es;
  logic [3:0]       e;
  logic [31:0]      rd;
  logic             er;
  logic [31:0]      rnd;
  logic [19:0]      st;
  logic [19:0]      nw;
  logic [3:0]       pat [5] = '{4'hF, 4'hE, 4'hC, 4'hA, 4'h8};
  logic [13:0]      sv = 14'h3CCC;
  int               n_mismatch = 0;
  int               checked = 0;
  integer           seed;

  always #50 clk = ~clk;

  e1_line_model mdl (
    .clk_i(clk), .crc_sync_o(crc), .bas_sync_o(bas), .smf_o(smf),
    .cw_o(cw), .nfas_o(nfas), .a_o(a), .sa6_o(s6), .sa7_o(s7),
    .estb_o(es), .e_o(e)
  );

  e1_nbit_monitor #(
    .LINKS(4), .RAI_CYCLES(RAI_C), .SEC_CYCLES(SEC_C)
  ) dut_u (
    .CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PSTRB_I(4'hF), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .CRC_MF_SYNC_I(crc), .BASIC_SYNC_I(bas),
    .SMF_BOUND_I(smf), .SA_CW_I(cw), .NFAS_STB_I(nfas), .A_BIT_I(a),
    .SA6_BIT_I(s6), .SA7_BIT_I(s7), .E_STB_I(es), .E_BIT_I(e),
    .INT_O(irq)
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] s, input logic [31:0] x,
                     input string what);
    checked++;
    if (s !== x) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, x, s);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [31:0] wd, input int lk);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {lk[1:0], idx, 2'b00};
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input logic [7:0] idx, input logic [31:0] m,
                      input logic [31:0] x, input string what);
    apb(1'b0, idx, 32'h0000_0000, 0);
    chk(rd & m, x, what);
  endtask : rchk

  task automatic ichk(input logic x, input string what);
    @(negedge clk);
    chk({31'b0, irq}, {31'b0, x}, what);
  endtask : ichk

  task automatic cwchk(input logic [19:0] x);
    for (int k = 0; k < 5; k++) begin
      rchk(8'(`OFS_SPARE4_CW + k), 32'h0000_00FF,
           {28'b0, x[(4-k)*4 +: 4]}, "codeword");
    end
  endtask : cwchk

  function automatic logic [4:0] chg(input logic [19:0] o,
                                     input logic [19:0] n);
    for (int k = 0; k < 5; k++) begin
      chg[k] = (o[k*4 +: 4] != n[k*4 +: 4]);
    end
  endfunction : chg

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    #3_000_000;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    seed = 32'h036f_9f0f;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rst_n = 1'b0;
    st = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int l = 0; l < 4; l++) begin
      for (int i = 'h56; i < 'h62; i++) begin
        apb(1'b0, i[7:0], 32'h0000_0000, l);
        chk(rd, 32'h0000_0000, "reset value");
        chk({31'b0, er}, {31'b0, i == 'h5E}, "error");
      end
    end
    apb(1'b1, `OFS_SPARE6_CW, 32'h0000_00FF, 0);
    rchk(`OFS_SPARE6_CW, 32'hFFFF_FFFF, 32'h0000_0000, "read only");
    apb(1'b1, `OFS_CW_IRQ_EN, 32'h0000_001F, 2);
    apb(1'b0, `OFS_CW_IRQ_EN, 32'h0000_0000, 2);
    chk(rd, 32'h0000_001F, "link 2 enable");
    rchk(`OFS_CW_IRQ_EN, 32'hFFFF_FFFF, 32'h0000_0000, "link 0");
    apb(1'b1, `OFS_CW_IRQ_EN, 32'h0000_0000, 2);
    mdl.sync(1'b1, 1'b0);
    repeat (4) begin
      rnd = $random(seed);
      nw = rnd[19:0];
      mdl.smf(nw);
      cwchk(nw);
      rchk(`OFS_CW_IRQ_FLAGS, 32'hFF, {27'b0, chg(st, nw)}, "chg");
      st = nw;
      apb(1'b1, `OFS_CW_IRQ_FLAGS, 32'h0000_00FF, 0);
    end
    rchk(`OFS_CW_IRQ_FLAGS, 32'hFF, 32'h0, "cleared");
    mdl.sync(1'b0, 1'b0);
    mdl.smf(~st);
    cwchk(st);
    rchk(`OFS_CW_IRQ_FLAGS, 32'hFF, 32'h0, "held flags");
    mdl.sync(1'b1, 1'b0);
    apb(1'b1, `OFS_CW_IRQ_EN, 32'h0000_0040, 0);
    nw = st ^ 20'h1_1111;
    mdl.smf(nw);
    cwchk(st);
    mdl.smf(nw);
    cwchk(nw);
    st = nw;
    ichk(1'b0, "masked change");
    apb(1'b1, `OFS_CW_IRQ_EN, 32'h0000_0044, 0);
    ichk(1'b1, "change irq");
    apb(1'b1, `OFS_CW_IRQ_FLAGS, 32'h0000_0004, 0);
    ichk(1'b0, "irq released");
    rchk(`OFS_CW_IRQ_FLAGS, 32'hFF, 32'h1B, "other flags");
    apb(1'b1, `OFS_CW_IRQ_FLAGS, 32'h0000_00FF, 0);
    apb(1'b1, `OFS_CW_IRQ_EN, 32'h0000_00A0, 0);
    for (int i = 0; i < 5; i++) begin
      repeat (3) mdl.smf({8'h00, pat[i], 8'h00});
      rchk(`OFS_PAT_FLAGS, 32'hFF, 32'h1 << (4 - i), "pat");
      rchk(`OFS_CW_IRQ_FLAGS, 32'h20, 32'h20, "summary");
      ichk(1'b1, "special irq");
      apb(1'b1, `OFS_PAT_FLAGS, 32'h0000_00FF, 0);
      apb(1'b1, `OFS_CW_IRQ_FLAGS, 32'h0000_00FF, 0);
      rchk(`OFS_PAT_FLAGS, 32'hFF, 32'h0, "pattern clear");
      ichk(1'b0, "special cleared");
    end
    apb(1'b1, `OFS_CW_IRQ_EN, 32'h0000_0000, 0);
    apb(1'b1, `OFS_OH_IRQ_FLAGS, 32'h0000_00FF, 0);
    for (int i = 1; i < 4; i++) begin
      mdl.smf({8'h00, i[3:0], 8'h00});
      rchk(`OFS_OH_IRQ_FLAGS, 32'h20, (i > 1) ? 32'h20 : 32'h0, "nt");
      ichk(1'b0, "nt crc masked");
      apb(1'b1, `OFS_OH_IRQ_EN, 32'h0000_0020, 0);
      ichk(i > 1, "nt crc irq");
      apb(1'b1, `OFS_OH_IRQ_EN, 32'h0000_0000, 0);
      apb(1'b1, `OFS_OH_IRQ_FLAGS, 32'h0000_00FF, 0);
    end
    for (int i = 0; i < 14; i++) begin
      mdl.nfas(1'b0, sv[13-i], 1'b1);
    end
    rchk(`OFS_PAT_FLAGS, 32'hFF, 32'h04, "sliding window");
    mdl.sync(1'b1, 1'b1);
    repeat (3) mdl.nfas(1'b0, 1'b0, 1'b1);
    rchk(`OFS_OH_STATE, 32'hFF, 32'h00, "no link id");
    repeat (2) mdl.nfas(1'b0, 1'b0, 1'b0);
    rchk(`OFS_OH_STATE, 32'hFF, 32'h01, "link id");
    rchk(`OFS_OH_IRQ_FLAGS, 32'hFF, 32'h01, "link change");
    mdl.nfas(1'b1, 1'b0, 1'b0);
    mdl.erun(1, 1'b0);
    rchk(`OFS_OH_STATE, 32'h04, 32'h00, "rai early");
    repeat (RAI_C) @(posedge clk);
    rchk(`OFS_OH_STATE, 32'h04, 32'h04, "rai");
    rchk(`OFS_OH_IRQ_FLAGS, 32'h04, 32'h04, "rai change");
    mdl.erun(3 * SEC_C, 1'b0);
    rchk(`OFS_OH_STATE, 32'h02, 32'h00, "febe early");
    mdl.erun(4 * SEC_C, 1'b0);
    rchk(`OFS_OH_STATE, 32'h02, 32'h02, "cont febe");
    rchk(`OFS_OH_IRQ_FLAGS, 32'h02, 32'h02, "febe change");
    wrap_up();
  end
endmodule : test_e1_national_bit_overhead_monitor
`default_nettype wire
